// file: hw/fdo_top.v
// Operation
// - cpu zone temperatures refresh from measurements
// - zones three/four host written or analog
// - absent or faulty diode reads 80h
// - filtered registers hold smoothed temperatures
// - smoothing strength set by separate control
// - report returns upper eight duty bits
// - without override or full, driven duty is largest bound source
// - bit 6 enables output one override
// - override duty runs value/256, above 100h reserved
// - low byte bit 7 is duty lsb
// - high byte gives output one bits 8:1
// - bit 6 enables output two override
// - output one override ignores all but full
// - output two override ignores all but full
// - next high byte gives output two bits
`timescale 1ns/100ps
`include "fdo_regs.vh"
module fdo_top (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire meas_valid,
  input wire [1:0] meas_zone,
  input wire [7:0] meas_temp,
  input wire [3:0] diode_fault,
  input wire [2:0] smooth_shift,
  input wire internal_from_analog,
  input wire external_from_analog,
  input wire [7:0] analog_input_eleven,
  input wire [7:0] analog_input_fifteen,
  input wire [8:0] one_lut_duty,
  input wire [8:0] one_loop_duty,
  input wire [8:0] two_lut_duty,
  input wire [8:0] two_loop_duty,
  input wire full_speed,
  output wire fan_out_one,
  output wire fan_out_two
);
  reg [7:0] zone_temp [0:3];
  reg [11:0] zone_filt [0:3];
  reg [7:0] internal_zone_temp;
  reg [7:0] external_digital_zone_temp;
  reg [7:0] an11_meta, an11_sync, an15_meta, an15_sync;
  reg [3:0] fault_meta, fault_sync;
  reg [7:0] one_low, one_high, two_low, two_high;
  wire [8:0] one_driven, two_driven;
  wire [8:0] one_auto = (one_lut_duty > one_loop_duty) ? one_lut_duty : one_loop_duty;
  wire [8:0] two_auto = (two_lut_duty > two_loop_duty) ? two_lut_duty : two_loop_duty;
  wire [11:0] sample_ext = {meas_temp, 4'h0};
  wire [11:0] filt_cur = zone_filt[meas_zone];
  wire [11:0] filt_diff = sample_ext - filt_cur;
  wire [11:0] filt_step = $signed(filt_diff) >>> smooth_shift;
  integer i;

  // zone order: 0 cpu1 a, 1 cpu1 b, 2 cpu2 a, 3 cpu2 b
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 4; i = i + 1) begin
        zone_temp[i] <= `FDO_RESET_VALUE;
        zone_filt[i] <= 12'h000;
      end
      an11_meta <= 8'h00;
      an11_sync <= 8'h00;
      an15_meta <= 8'h00;
      an15_sync <= 8'h00;
      fault_meta <= 4'h0;
      fault_sync <= 4'h0;
    end else begin
      an11_meta <= analog_input_eleven;
      an11_sync <= an11_meta;
      an15_meta <= analog_input_fifteen;
      an15_sync <= an15_meta;
      fault_meta <= diode_fault;
      fault_sync <= fault_meta;
      if (meas_valid) begin
        zone_temp[meas_zone] <= meas_temp;
        zone_filt[meas_zone] <= filt_cur + filt_step;
      end
    end
  end

  function [7:0] zone_read;
    input [1:0] z;
    input filt;
    begin
      if (fault_sync[z])
        zone_read = `FDO_FAULT_CODE;
      else if (filt)
        zone_read = zone_filt[z][11:4];
      else
        zone_read = zone_temp[z];
    end
  endfunction

  always @(posedge clk) begin
    if (reset) begin
      internal_zone_temp <= `FDO_RESET_VALUE;
      external_digital_zone_temp <= `FDO_RESET_VALUE;
      one_low <= `FDO_RESET_VALUE;
      one_high <= `FDO_RESET_VALUE;
      two_low <= `FDO_RESET_VALUE;
      two_high <= `FDO_RESET_VALUE;
    end else begin
      if (internal_from_analog)
        internal_zone_temp <= an11_sync;
      else if (reg_write && reg_addr == `FDO_ADDR_INTERNAL_TEMP)
        internal_zone_temp <= reg_wdata;
      if (external_from_analog)
        external_digital_zone_temp <= an15_sync;
      else if (reg_write && reg_addr == `FDO_ADDR_EXT_DIGITAL_TEMP)
        external_digital_zone_temp <= reg_wdata;
      if (reg_write) begin
        case (reg_addr)
          `FDO_ADDR_ONE_OVR_LOW: one_low <= reg_wdata & `FDO_OVR_LOW_MASK;
          `FDO_ADDR_ONE_OVR_HIGH: one_high <= reg_wdata;
          `FDO_ADDR_TWO_OVR_LOW: two_low <= reg_wdata & `FDO_OVR_LOW_MASK;
          `FDO_ADDR_TWO_OVR_HIGH: two_high <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `FDO_ADDR_CPU1_B_TEMP: reg_rdata <= zone_read(2'd1, 1'b0);
        `FDO_ADDR_CPU2_B_TEMP: reg_rdata <= zone_read(2'd3, 1'b0);
        `FDO_ADDR_CPU1_B_FILT: reg_rdata <= zone_read(2'd1, 1'b1);
        `FDO_ADDR_CPU2_B_FILT: reg_rdata <= zone_read(2'd3, 1'b1);
        `FDO_ADDR_ONE_REPORT: reg_rdata <= one_driven[8:1];
        `FDO_ADDR_TWO_REPORT: reg_rdata <= two_driven[8:1];
        `FDO_ADDR_ONE_OVR_LOW: reg_rdata <= one_low;
        `FDO_ADDR_ONE_OVR_HIGH: reg_rdata <= one_high;
        `FDO_ADDR_TWO_OVR_LOW: reg_rdata <= two_low;
        `FDO_ADDR_TWO_OVR_HIGH: reg_rdata <= two_high;
        `FDO_ADDR_CPU1_A_TEMP: reg_rdata <= zone_read(2'd0, 1'b0);
        `FDO_ADDR_CPU2_A_TEMP: reg_rdata <= zone_read(2'd2, 1'b0);
        `FDO_ADDR_INTERNAL_TEMP: reg_rdata <= internal_zone_temp;
        `FDO_ADDR_EXT_DIGITAL_TEMP: reg_rdata <= external_digital_zone_temp;
        `FDO_ADDR_CPU1_A_FILT: reg_rdata <= zone_read(2'd0, 1'b1);
        `FDO_ADDR_CPU2_A_FILT: reg_rdata <= zone_read(2'd2, 1'b1);
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  fdo_fan_channel u_one (
    .clk(clk),
    .reset(reset),
    .auto_duty(one_auto),
    .override_duty({one_high, one_low[`FDO_OVR_LSB_BIT]}),
    .override_enable(one_low[`FDO_OVR_EN_BIT]),
    .full_speed(full_speed),
    .driven_duty(one_driven),
    .fan_out(fan_out_one)
  );

  fdo_fan_channel u_two (
    .clk(clk),
    .reset(reset),
    .auto_duty(two_auto),
    .override_duty({two_high, two_low[`FDO_OVR_LSB_BIT]}),
    .override_enable(two_low[`FDO_OVR_EN_BIT]),
    .full_speed(full_speed),
    .driven_duty(two_driven),
    .fan_out(fan_out_two)
  );
endmodule

// file: hw/fdo_regs.vh
`ifndef FDO_REGS_VH
`define FDO_REGS_VH
`define FDO_ADDR_CPU1_B_TEMP 8'h06
`define FDO_ADDR_CPU2_B_TEMP 8'h07
`define FDO_ADDR_CPU1_B_FILT 8'h08
`define FDO_ADDR_CPU2_B_FILT 8'h09
`define FDO_ADDR_ONE_REPORT 8'h0a
`define FDO_ADDR_TWO_REPORT 8'h0b
`define FDO_ADDR_ONE_OVR_LOW 8'h0c
`define FDO_ADDR_ONE_OVR_HIGH 8'h0d
`define FDO_ADDR_TWO_OVR_LOW 8'h0e
`define FDO_ADDR_TWO_OVR_HIGH 8'h0f
`define FDO_ADDR_CPU1_A_TEMP 8'h50
`define FDO_ADDR_CPU2_A_TEMP 8'h51
`define FDO_ADDR_INTERNAL_TEMP 8'h52
`define FDO_ADDR_EXT_DIGITAL_TEMP 8'h53
`define FDO_ADDR_CPU1_A_FILT 8'h54
`define FDO_ADDR_CPU2_A_FILT 8'h55
`define FDO_OVR_LSB_BIT 7
`define FDO_OVR_EN_BIT 6
`define FDO_OVR_LOW_MASK 8'hc0
`define FDO_RESET_VALUE 8'h00
`define FDO_FAULT_CODE 8'h80
`define FDO_DUTY_FULL 9'h100
`define FDO_PERIOD_MAX 8'hff
`define FDO_SMOOTH_SHIFT_MAX 3'h7
`endif

// file: hw/fdo_fan_channel.v
`timescale 1ns/100ps
`include "fdo_regs.vh"
module fdo_fan_channel (
  input wire clk,
  input wire reset,
  input wire [8:0] auto_duty,
  input wire [8:0] override_duty,
  input wire override_enable,
  input wire full_speed,
  output reg [8:0] driven_duty,
  output reg fan_out
);
  reg [7:0] phase;
  reg [8:0] next_duty;
  always @* begin
    // source merge: override excludes all but full speed
    if (full_speed)
      next_duty = `FDO_DUTY_FULL;
    else if (override_enable)
      next_duty = (override_duty > `FDO_DUTY_FULL) ? `FDO_DUTY_FULL : override_duty;
    else
      next_duty = auto_duty;
  end
  always @(posedge clk) begin
    if (reset) begin
      phase <= 8'h00;
      driven_duty <= 9'h000;
      fan_out <= 1'b0;
    end else begin
      phase <= phase + 8'h01;
      // new duty only at a period boundary, avoids runt pulses
      if (phase == `FDO_PERIOD_MAX)
        driven_duty <= next_duty;
      // high while phase below duty/256 of the period
      fan_out <= ({1'b0, phase} < driven_duty);
    end
  end
endmodule

// file: tb/fdo_fan_meter.sv
`timescale 1ns/100ps
module fdo_fan_meter (
  input logic clk,
  input logic start,
  input logic fan_in,
  output logic [8:0] high_count
);
  logic [8:0] left;
  // a 256-cycle window covers one whole period whatever its phase
  always @(posedge clk) begin
    if (start) begin
      left <= 9'h100;
      high_count <= 9'h000;
    end else if (left != 9'h000) begin
      left <= left - 9'h001;
      high_count <= high_count + {8'h00, fan_in};
    end
  end
endmodule

// file: tb/fdo_top_assertions.sv
`timescale 1ns/100ps
module fdo_checker (
  input logic clk,
  input logic reset,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_write,
  input logic reg_read,
  input logic [7:0] reg_rdata,
  input logic [3:0] diode_fault,
  input logic full_speed,
  input logic external_from_analog,
  input logic fan_out_one,
  input logic fan_out_two
);
  logic [8:0] fs;
  // saturates once full speed has spanned a whole period
  always @(posedge clk) fs <= (reset || !full_speed) ? 9'h000 : fs + {8'h00, fs != 9'h104};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_full_one: assert property (fs == 9'h104 |-> fan_out_one) else $error("full one");
  chk_full_two: assert property (fs == 9'h104 |-> fan_out_two) else $error("full two");
  chk_full_report: assert property (fs == 9'h104 && reg_read && reg_addr == 8'h0a
    |=> reg_rdata == 8'h80) else $error("report");
  chk_fault_code: assert property (diode_fault[0] && $past(diode_fault[0], 4)
    && reg_read && reg_addr == 8'h50 |=> reg_rdata == 8'h80) else $error("fault");
  chk_low_mask: assert property (reg_read && reg_addr == 8'h0c
    |=> reg_rdata[5:0] == 6'h00) else $error("low bits");
  chk_low_back: assert property (reg_write && reg_addr == 8'h0c ##1 reg_read && reg_addr == 8'h0c
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'hc0)) else $error("low");
  chk_high_back: assert property (reg_write && reg_addr == 8'h0d ##1 reg_read && reg_addr == 8'h0d
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("high");
  chk_zone_four: assert property (reg_write && reg_addr == 8'h53 && !external_from_analog
    ##1 reg_read && reg_addr == 8'h53 |=> reg_rdata == $past(reg_wdata, 2)) else $error("zone");
endmodule
bind fdo_top fdo_checker chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .diode_fault, .full_speed, .external_from_analog, .fan_out_one, .fan_out_two);

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk, reset, reg_write, reg_read, meas_valid, full_speed, start, fan_out_one, fan_out_two;
  logic internal_from_analog, external_from_analog;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, meas_temp, analog_input_eleven, analog_input_fifteen;
  logic [1:0] meas_zone;
  logic [3:0] diode_fault;
  logic [2:0] smooth_shift;
  logic [8:0] one_lut_duty, one_loop_duty, two_lut_duty, two_loop_duty, hi, hi_two;
  int n_mismatch = 0;
  int n_compared = 0;
  fdo_top uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .meas_valid, .meas_zone, .meas_temp, .diode_fault, .smooth_shift, .internal_from_analog,
    .external_from_analog, .analog_input_eleven, .analog_input_fifteen, .one_lut_duty,
    .one_loop_duty, .two_lut_duty, .two_loop_duty, .full_speed, .fan_out_one, .fan_out_two);
  fdo_fan_meter meter (.clk, .start, .fan_in(fan_out_one), .high_count(hi));
  // second output is otherwise seen only at full speed
  fdo_fan_meter meter_two (.clk, .start, .fan_in(fan_out_two), .high_count(hi_two));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(string nm, logic [8:0] e, logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    cyc(1);
    reg_write = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_addr = a;
    reg_read = 1;
    cyc(1);
    reg_read = 0;
    cmp($sformatf("reg %h", a), {1'b0, e}, {1'b0, reg_rdata});
  endtask
  task automatic ms(logic [7:0] t);
    meas_temp = t;
    meas_valid = 1;
    cyc(1);
    meas_valid = 0;
    cyc(8);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {reg_write, reg_read, meas_valid, full_speed, start, diode_fault, smooth_shift} = 0;
    {reg_addr, reg_wdata, meas_temp, analog_input_eleven, analog_input_fifteen} = 0;
    {internal_from_analog, external_from_analog, one_lut_duty, one_loop_duty} = 0;
    {two_lut_duty, two_loop_duty} = 0;
    meas_zone = 2'd1;
    reset = 1;
    cyc(5);
    reset = 0;
    for (int i = 0; i < 16; i++) rd(8'(i < 10 ? 6 + i : 70 + i), 8'h00);
    rd(8'hf0, 8'h00);
    $display("test reset values done");
    ms(8'h3c);
    rd(8'h06, 8'h3c);
    rd(8'h08, 8'h3c);
    smooth_shift = 3'd1;
    ms(8'h5c);
    wr(8'h06, 8'hff);
    rd(8'h06, 8'h5c);
    rd(8'h08, 8'h4c);
    diode_fault = 4'h1;
    cyc(8);
    rd(8'h50, 8'h80);
    diode_fault = 4'h0;
    wr(8'h53, 8'ha5);
    rd(8'h53, 8'ha5);
    {external_from_analog, internal_from_analog} = 2'b11;
    {analog_input_fifteen, analog_input_eleven} = 16'h2d17;
    cyc(8);
    rd(8'h53, 8'h2d);
    rd(8'h52, 8'h17);
    $display("test temperatures done");
    {one_lut_duty, one_loop_duty, two_lut_duty, two_loop_duty} = {9'h040, 9'h060, 9'h030, 9'h031};
    cyc(300);
    rd(8'h0a, 8'h30);
    rd(8'h0b, 8'h18);
    wr(8'h0d, 8'h12);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'hc0);
    rd(8'h0d, 8'h12);
    wr(8'h0f, 8'h40);
    wr(8'h0e, 8'h40);
    cyc(300);
    rd(8'h0a, 8'h12);
    rd(8'h0b, 8'h40);
    start = 1;
    cyc(1);
    start = 0;
    cyc(258);
    cmp("fan one high", 9'h025, hi);
    cmp("fan two high", 9'h080, hi_two);
    $display("test override done");
    full_speed = 1;
    cyc(300);
    rd(8'h0a, 8'h80);
    rd(8'h0b, 8'h80);
    full_speed = 0;
    wr(8'h0c, 8'h00);
    wr(8'h0e, 8'h80);
    cyc(300);
    rd(8'h0a, 8'h30);
    rd(8'h0b, 8'h18);
    $display("test full speed done");
    give_verdict;
  end
  initial begin
    // about six and a half times the expected run
    #250000;
    n_mismatch++;
    give_verdict;
  end
endmodule
